// file: pkg/byte_op_consts.vh
`ifndef BYTE_OP_CONSTS_VH
`define BYTE_OP_CONSTS_VH
// ----------------------------------------
// operation select codes
// ----------------------------------------
`define OP_NONE 3'h0
`define OP_DECREMENT_REG 3'h1
`define OP_DECREMENT_SKIP 3'h2
`define OP_INCREMENT_REG 3'h3
`define OP_INCREMENT_SKIP 3'h4
`define OP_OR_LITERAL 3'h5
`define OP_ABSOLUTE_JUMP 3'h6
// ----------------------------------------
// widths and fields
// ----------------------------------------
`define PC_WIDTH 15
`define JUMP_LOW_WIDTH 11
`define LATCH_JUMP_HI 6
`define LATCH_JUMP_LO 3
// ----------------------------------------
// reset values
// ----------------------------------------
`define ACC_RESET 8'h00
`define PC_RESET 15'h0000
`define ZERO_FLAG_RESET 1'b0
`define WRITE_DATA_RESET 8'h00
`endif

// file: src/zero_detect.v
`timescale 1ns/100ps
`default_nettype none
module zero_detect #(
    parameter WIDTH = 8
) (
    input wire [WIDTH-1:0] value,
    output wire is_zero
);
    assign is_zero = (value == {WIDTH{1'b0}});
endmodule
`default_nettype wire

// file: src/byte_op_branch_exec.v
`timescale 1ns/100ps
`default_nettype none
`include "byte_op_consts.vh"
module byte_op_branch_exec (
    input wire clk,
    input wire rst,
    input wire op_valid,
    input wire [2:0] op_code,
    input wire target_choice_bit,
    input wire [7:0] reg_value,
    input wire [7:0] literal,
    input wire [10:0] jump_operand,
    input wire [7:0] upper_jump_latch,
    output reg [7:0] acc,
    output reg equal_nil_flag,
    output reg reg_write,
    output reg [7:0] reg_write_data,
    output reg [14:0] pc,
    output reg pc_load,
    output reg discard_next,
    output wire op_ready
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_SECOND = 1'b1;
    reg state_reg;
    reg state_next;
    reg [7:0] result;
    wire result_zero;
    reg [7:0] acc_next;
    reg flag_next;
    reg wr_next;
    reg [7:0] wr_data_next;
    reg [14:0] pc_next;
    reg pc_load_next;
    reg discard_next_next;
    wire take;
    // ----------------------------------------
    // decode wires
    // ----------------------------------------
    wire is_dec;
    wire is_inc;
    wire is_dec_skip;
    wire is_inc_skip;
    wire is_jump;
    wire is_skip_op;
    wire flag_step;
    wire skip_taken;
    wire stall_op;
    wire [14:0] jump_target;

    // second cycle of a jump or a taken skip holds off the next op
    assign op_ready = (state_reg == ST_IDLE);
    assign take = op_valid && op_ready;

    zero_detect #(
        .WIDTH(8)
    ) u_zero_detect (
        .value(result),
        .is_zero(result_zero)
    );

    // ----------------------------------------
    // op decode
    // ----------------------------------------
    assign is_dec = (op_code == `OP_DECREMENT_REG);
    assign is_inc = (op_code == `OP_INCREMENT_REG);
    assign is_dec_skip = (op_code == `OP_DECREMENT_SKIP);
    assign is_inc_skip = (op_code == `OP_INCREMENT_SKIP);
    assign is_jump = (op_code == `OP_ABSOLUTE_JUMP);
    assign is_skip_op = is_dec_skip || is_inc_skip;
    assign flag_step = is_dec || is_inc;
    assign skip_taken = is_skip_op && result_zero;
    assign stall_op = skip_taken || is_jump;
    assign jump_target = {
        upper_jump_latch[`LATCH_JUMP_HI:`LATCH_JUMP_LO],
        jump_operand
    };

    // ----------------------------------------
    // result path
    // ----------------------------------------
    always @* begin
        case (op_code)
            `OP_DECREMENT_REG: result = reg_value - 8'h01;
            `OP_DECREMENT_SKIP: result = reg_value - 8'h01;
            `OP_INCREMENT_REG: result = reg_value + 8'h01;
            `OP_INCREMENT_SKIP: result = reg_value + 8'h01;
            `OP_OR_LITERAL: result = acc | literal;
            default: result = 8'h00;
        endcase
    end

    // ----------------------------------------
    // next outputs
    // ----------------------------------------
    always @* begin
        acc_next = acc;
        flag_next = equal_nil_flag;
        wr_next = 1'b0;
        wr_data_next = reg_write_data;
        pc_next = pc;
        pc_load_next = 1'b0;
        discard_next_next = 1'b0;
        if (take) begin
            case (op_code)
                `OP_DECREMENT_REG, `OP_INCREMENT_REG,
                `OP_DECREMENT_SKIP, `OP_INCREMENT_SKIP: begin
                    if (target_choice_bit) begin
                        wr_next = 1'b1;
                        wr_data_next = result;
                    end else begin
                        acc_next = result;
                    end
                    if (flag_step) begin
                        flag_next = result_zero;
                    end
                    if (skip_taken) begin
                        discard_next_next = 1'b1;
                    end
                end
                `OP_OR_LITERAL: begin
                    acc_next = result;
                    flag_next = result_zero;
                end
                `OP_ABSOLUTE_JUMP: begin
                    pc_next = jump_target;
                    pc_load_next = 1'b1;
                end
                // codes 0 and 7 leave everything as it was
                default: begin
                    acc_next = acc;
                end
            endcase
        end
    end

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    // two-cycle ops hold off the next one
    always @* begin
        case (state_reg)
            ST_IDLE: begin
                if (take && stall_op) begin
                    state_next = ST_SECOND;
                end else begin
                    state_next = ST_IDLE;
                end
            end
            // the refused cycle stands in for the nop
            ST_SECOND: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // datapath registers
    // ----------------------------------------
    // acc, flag and pc hold until an op changes them
    always @(posedge clk) begin
        if (rst) begin
            acc <= `ACC_RESET;
            equal_nil_flag <= `ZERO_FLAG_RESET;
            reg_write_data <= `WRITE_DATA_RESET;
            pc <= `PC_RESET;
        end else begin
            acc <= acc_next;
            equal_nil_flag <= flag_next;
            reg_write_data <= wr_data_next;
            pc <= pc_next;
        end
    end

    // ----------------------------------------
    // strobe registers
    // ----------------------------------------
    // pulses clear in each cycle that takes no op, so a taken op pulses each strobe for at most one cycle
    always @(posedge clk) begin
        if (rst) begin
            reg_write <= 1'b0;
            pc_load <= 1'b0;
            discard_next <= 1'b0;
        end else begin
            reg_write <= wr_next;
            pc_load <= pc_load_next;
            discard_next <= discard_next_next;
        end
    end
endmodule
`default_nettype wire

// file: sim/byte_op_checker_sva.sv
`timescale 1ns/100ps
`default_nettype none
module byte_op_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire logic target_choice_bit,
    input wire logic op_ready,
    input wire logic [2:0] op_code,
    input wire logic [7:0] reg_value,
    input wire logic [7:0] literal,
    input wire logic [7:0] upper_jump_latch,
    input wire logic [10:0] jump_operand,
    input wire logic [7:0] acc,
    input wire logic [7:0] reg_write_data,
    input wire logic equal_nil_flag,
    input wire logic reg_write,
    input wire logic pc_load,
    input wire logic discard_next,
    input wire logic [14:0] pc
);
    // ----
    // checks
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire tk = op_valid && op_ready;
    wire [14:0] jt = {upper_jump_latch[6:3], jump_operand};
    wire sk = op_code == 3'h2 && reg_value == 8'h01
        || op_code == 3'h4 && reg_value == 8'hff;
    wire ks = op_code == 3'h2 || op_code == 3'h4;
    jump_target_a: assert property (tk && op_code == 3'h6
        |=> pc_load && pc == $past(jt)) else $error("jump pc");
    jump_stall_a: assert property (tk && (op_code == 3'h6 || sk)
        |=> !op_ready ##1 op_ready) else $error("stall");
    jump_quiet_a: assert property (tk && op_code == 3'h6
        |=> $stable(equal_nil_flag) && !reg_write) else $error("jump side");
    dec_acc_a: assert property (tk && op_code == 3'h1 && !target_choice_bit
        |=> acc == $past(reg_value) - 8'h01
        && equal_nil_flag == (acc == 8'h00)) else $error("dec");
    inc_reg_a: assert property (tk && op_code == 3'h3 && target_choice_bit
        |=> reg_write && reg_write_data == $past(reg_value) + 8'h01
        && equal_nil_flag == (reg_write_data == 8'h00)) else $error("inc");
    or_lit_a: assert property (tk && op_code == 3'h5
        |=> acc == ($past(acc) | $past(literal))
        && equal_nil_flag == (acc == 8'h00)) else $error("or");
    skip_zero_a: assert property (tk && ks
        |=> discard_next == $past(sk)) else $error("skip");
    skip_flag_a: assert property (tk && ks
        |=> $stable(equal_nil_flag)) else $error("skip flag");
endmodule
bind byte_op_branch_exec byte_op_checker u_byte_op_checker (
    .clk(clk),
    .rst(rst),
    .op_valid(op_valid),
    .target_choice_bit(target_choice_bit),
    .op_ready(op_ready),
    .op_code(op_code),
    .reg_value(reg_value),
    .literal(literal),
    .upper_jump_latch(upper_jump_latch),
    .jump_operand(jump_operand),
    .acc(acc),
    .reg_write_data(reg_write_data),
    .equal_nil_flag(equal_nil_flag),
    .reg_write(reg_write),
    .pc_load(pc_load),
    .discard_next(discard_next),
    .pc(pc)
);
`default_nettype wire

// file: sim/byte_op_branch_exec_tb.sv
`timescale 1ns/100ps
`default_nettype none
module byte_op_branch_exec_tb;
    logic clk = 0, rst = 1, op_valid = 0, target_choice_bit = 0, tk_d = 0;
    logic [2:0] op_code = 3'h0;
    logic [7:0] reg_value = 8'h00, literal = 8'h00, upper_jump_latch = 8'h00;
    logic [10:0] jump_operand = 11'h000;
    logic [7:0] acc, reg_write_data, ma = 8'h00, md = 8'h00;
    logic equal_nil_flag, reg_write, pc_load, discard_next, op_ready, mf = 0;
    logic [14:0] pc, mp = 15'h0000;
    logic [35:0] exp_q[$];
    logic [35:0] want;
    int miscompares = 0, comparisons = 0, cyc = 0;
    byte_op_branch_exec u_byte_op_branch_exec (
        .clk(clk),
        .rst(rst),
        .op_valid(op_valid),
        .op_code(op_code),
        .target_choice_bit(target_choice_bit),
        .reg_value(reg_value),
        .literal(literal),
        .jump_operand(jump_operand),
        .upper_jump_latch(upper_jump_latch),
        .acc(acc),
        .equal_nil_flag(equal_nil_flag),
        .reg_write(reg_write),
        .reg_write_data(reg_write_data),
        .pc(pc),
        .pc_load(pc_load),
        .discard_next(discard_next),
        .op_ready(op_ready)
    );
    // ----
    // driver and monitor
    // ----
    initial forever #2.5 clk = ~clk;
    task automatic chk(input logic [35:0] seen, input logic [35:0] want);
        comparisons++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: %h vs %h", $time, seen, want);
        end
    endtask
    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic op(input logic [2:0] c, input logic t, input logic [7:0] r, l);
        logic [7:0] res;
        logic ar, tkn, st;
        op_valid <= 1'b1;
        op_code <= c;
        target_choice_bit <= t;
        reg_value <= r;
        literal <= l;
        jump_operand <= 11'($urandom);
        upper_jump_latch <= 8'($urandom);
        // refused cycles hold the request
        do begin
            @(negedge clk);
            tkn = op_ready;
            @(posedge clk);
        end while (tkn !== 1'b1);
        res = (c == 3'h1 || c == 3'h2) ? r - 8'h01 : r + 8'h01;
        ar = c >= 3'h1 && c <= 3'h4;
        if (ar && t) md = res;
        if (ar && !t) ma = res;
        if (c == 3'h1 || c == 3'h3) mf = res == 8'h00;
        if (c == 3'h5) ma = ma | l;
        if (c == 3'h5) mf = ma == 8'h00;
        if (c == 3'h6) mp = {upper_jump_latch[6:3], jump_operand};
        // stall after a jump or a zero skip
        st = (c == 3'h2 || c == 3'h4) && res == 8'h00 || c == 3'h6;
        exp_q.push_back({ma, mf, ar && t, md, c == 3'h6, mp,
            st && c != 3'h6, !st});
    endtask
    always @(posedge clk) begin
        tk_d <= op_valid && op_ready && !rst;
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            miscompares++;
            results();
        end
    end
    always @(negedge clk) begin
        if (tk_d) begin
            want = exp_q.pop_front();
            chk(acc, want[35:28]);
            chk(equal_nil_flag, want[27]);
            chk(reg_write, want[26]);
            chk(reg_write_data, want[25:18]);
            chk(pc_load, want[17]);
            chk(pc, want[16:2]);
            chk(discard_next, want[1]);
            chk(op_ready, want[0]);
        end
    end
    initial begin
        void'($urandom(53170));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        op(3'h5, 1'b0, 8'h00, 8'h00);
        op(3'h1, 1'b0, 8'h01, 8'h00);
        op(3'h2, 1'b1, 8'h01, 8'h00);
        op(3'h4, 1'b0, 8'hff, 8'h00);
        op(3'h6, 1'b0, 8'h00, 8'h00);
        op(3'h3, 1'b1, 8'hff, 8'h00);
        op(3'h7, 1'b1, 8'h00, 8'h00);
        $display("directed test done");
        repeat (200) op(3'($urandom), 1'($urandom), $urandom_range(0, 1) ?
            8'($urandom) : 8'($urandom_range(0, 2)) - 8'h01,
            $urandom_range(0, 1) ? 8'h00 : 8'($urandom));
        op_valid <= 1'b0;
        repeat (3) @(posedge clk);
        $display("random test done");
        results();
    end
endmodule
`default_nettype wire
